// >>> core/mcast_snoop.sv
// multicast snooping forwarding decision for a packet switch
// assumes frame descriptors and register port come from logic on mclk
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
// Function
// - learned router ports added when learning enabled
// - configurable default router port map used too
// - per-port router timer restarts on message
// - expired router port leaves learned map
// - data: table map plus routers, else fallback
// - hardware snooping sends reports to routers
// - known query: table map plus routers
// - unknown query: L2 map on L2 hit, else default map, plus routers
// - software snooping traps control to CPU
// - IGMP is protocol 2 with listed types
// - MLD is next header 58, listed types
// - CPU-injected control forwarded by message class
// - software-filled L3 table with addresses, maps
// - include entry needs source and destination match
// - exclude entry drops matching source, forwards others
// - exclude has its own mode, include entries never drop
// - don't-care entry matches destination only
// - all-zero port map deletes the entry
module mcast_snoop
	import mcast_snoop_pkg::*;
#(
	parameter int          NPORTS    = 8,
	parameter int          ENTRIES   = 8,
	parameter int          CPU_PORT  = 7,
	parameter int unsigned AGE_INIT  = AGE_RESET,
	parameter int          PW        = $clog2(NPORTS),
	parameter int          EW        = $clog2(ENTRIES)
) (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	input  wire logic              frm_valid,
	output logic                   frm_ready,
	input  wire logic [PW-1:0]     frm_port,
	input  wire logic              frm_ipv4,
	input  wire logic              frm_ipv6,
	input  wire logic [7:0]        frm_proto,
	input  wire logic [7:0]        frm_type,
	input  wire logic [127:0]      frm_src_ip,
	input  wire logic [127:0]      frm_dst_ip,
	input  wire logic              frm_l2_hit,
	input  wire logic [NPORTS-1:0] frm_l2_map,
	output logic                   res_valid,
	output logic      [NPORTS-1:0] res_map,
	output logic                   res_drop
);
	localparam int W = 256 + 2 + NPORTS;

	// frame classes
	localparam logic [1:0] CLS_DATA   = 2'h0;
	localparam logic [1:0] CLS_HOST   = 2'h1;
	localparam logic [1:0] CLS_ROUTER = 2'h2;

	// configuration and table staging
	logic [2:0]          ctrl;
	logic [NPORTS-1:0]   def_router;
	logic [NPORTS-1:0]   def_mcast;
	logic [31:0]         age_period;
	logic [127:0]        ent_src;
	logic [127:0]        ent_dst;
	logic [1:0]          ent_mode;
	logic [NPORTS-1:0]   ent_map;
	logic [ENTRIES-1:0]  ent_valid;
	logic [NPORTS-1:0]   learned;

	// lookup state
	scan_state_e         state;
	logic [EW:0]         scan_idx;
	logic                rd_pend;
	logic [EW-1:0]       rd_idx;
	logic [1:0]          cls;
	logic                cpu_src;
	logic [127:0]        key_src;
	logic [127:0]        key_dst;
	logic                key_l2_hit;
	logic [NPORTS-1:0]   key_l2_map;
	logic                hit;
	logic                hit_drop;
	logic [NPORTS-1:0]   hit_map;
	logic                last_drop;

	logic                accept;
	logic                cmd_go;
	logic [1:0]          next_cls;
	logic [NPORTS-1:0]   router_map;
	logic [NPORTS-1:0]   fwd_map;
	logic [NPORTS-1:0]   next_map;
	logic                next_drop;
	logic [127:0]        e_src;
	logic [127:0]        e_dst;
	logic [1:0]          e_mode;
	logic [NPORTS-1:0]   e_map;
	logic                e_hit;
	logic                e_drop;

	table_if #(.W(W), .AW(EW)) tbl ();

	localparam logic [NPORTS-1:0] CPU_MASK = NPORTS'(1) << CPU_PORT;

	// classify an IGMP or MLD frame by protocol and message type
	function automatic logic [1:0] classify(input logic v4, input logic v6,
	                                        input logic [7:0] proto, input logic [7:0] typ);
		logic [1:0] c;
		c = CLS_DATA;
		if (v4 && proto == PROTO_IGMP) begin
			if (typ == IGMP_V1_REP || typ == IGMP_V2_REP || typ == IGMP_LEAVE ||
			    typ == IGMP_HOST_A || typ == IGMP_HOST_B || typ == IGMP_HOST_C) begin
				c = CLS_HOST;
			end else if (typ == IGMP_QUERY || typ == IGMP_RTR_A || typ == IGMP_RTR_B) begin
				c = CLS_ROUTER;
			end
		end
		if (v6 && proto == NEXT_HDR_MLD) begin
			if (typ >= MLD_HOST_LO && typ <= MLD_HOST_HI) begin
				c = CLS_HOST;
			end else if (typ == MLD_QUERY || (typ >= MLD_RTR_LO && typ <= MLD_RTR_HI)) begin
				c = CLS_ROUTER;
			end
		end
		return c;
	endfunction

	assign frm_ready = (state == ST_IDLE);
	assign accept    = frm_valid && frm_ready;
	assign next_cls  = classify(frm_ipv4, frm_ipv6, frm_proto, frm_type);
	assign cmd_go    = reg_wr && reg_addr == REG_ENT_CMD && reg_wdata[CMD_GO];

	// configuration registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl       <= CTRL_RESET;
			def_router <= '0;
			def_mcast  <= '0;
			age_period <= AGE_INIT;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_CTRL:       ctrl       <= reg_wdata[2:0];
				REG_DEF_ROUTER: def_router <= reg_wdata[NPORTS-1:0];
				REG_DEF_MCAST:  def_mcast  <= reg_wdata[NPORTS-1:0];
				REG_AGE_PERIOD: age_period <= reg_wdata;
				default: ;
			endcase
		end
	end

	// entry staging registers, four words per address
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ent_src  <= '0;
			ent_dst  <= '0;
			ent_mode <= MODE_INCLUDE;
			ent_map  <= '0;
		end else if (reg_wr) begin
			if (reg_addr[7:4] == REG_ENT_SRC[7:4]) begin
				ent_src[32*reg_addr[3:2] +: 32] <= reg_wdata;
			end
			if (reg_addr[7:4] == REG_ENT_DST[7:4]) begin
				ent_dst[32*reg_addr[3:2] +: 32] <= reg_wdata;
			end
			if (reg_addr == REG_ENT_CFG) begin
				ent_map  <= reg_wdata[NPORTS-1:0];
				ent_mode <= reg_wdata[CFG_MODE_LSB +: 2];
			end
		end
	end

	// software commits staged entry to the table
	assign tbl.wr_en   = cmd_go;
	assign tbl.wr_addr = reg_wdata[EW-1:0];
	assign tbl.wr_data = {ent_src, ent_dst, ent_mode, ent_map};

	// entry valid bits
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ent_valid <= '0;
		end else if (cmd_go) begin
			// an empty port map deletes the entry
			ent_valid[reg_wdata[EW-1:0]] <= (ent_map != '0);
		end
	end

	// register read, data in the cycle after the strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			reg_rdata <= 32'h0;
			if (reg_addr[7:4] == REG_ENT_SRC[7:4]) begin
				reg_rdata <= ent_src[32*reg_addr[3:2] +: 32];
			end else if (reg_addr[7:4] == REG_ENT_DST[7:4]) begin
				reg_rdata <= ent_dst[32*reg_addr[3:2] +: 32];
			end else begin
				case (reg_addr)
					REG_CTRL:       reg_rdata <= 32'(ctrl);
					REG_DEF_ROUTER: reg_rdata <= 32'(def_router);
					REG_DEF_MCAST:  reg_rdata <= 32'(def_mcast);
					REG_AGE_PERIOD: reg_rdata <= age_period;
					REG_LEARNED:    reg_rdata <= 32'(learned);
					REG_STATUS:     reg_rdata <= {30'h0, last_drop, state != ST_IDLE};
					REG_ENT_CFG:    reg_rdata <= 32'(ent_map) | (32'(ent_mode) << CFG_MODE_LSB);
					REG_ENT_VALID:  reg_rdata <= 32'(ent_valid);
					default:        reg_rdata <= 32'h0;
				endcase
			end
		end
	end

	// router messages from ingress ports restart the timer
	// the aging module drops ports whose timer ran out
	router_aging #(
		.NPORTS (NPORTS),
		.PW     (PW)
	) u_aging (
		.mclk       (mclk),
		.reset_n    (reset_n),
		.learn      (accept && ctrl[CTRL_LEARN] && next_cls == CLS_ROUTER && frm_port != PW'(CPU_PORT)),
		.learn_port (frm_port),
		.period     (age_period),
		.learned    (learned)
	);

	entry_mem #(
		.DEPTH (ENTRIES)
	) u_mem (
		.mclk (mclk),
		.tbl  (tbl)
	);

	// latch the descriptor of an accepted frame
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cls        <= CLS_DATA;
			cpu_src    <= 1'b0;
			key_src    <= '0;
			key_dst    <= '0;
			key_l2_hit <= 1'b0;
			key_l2_map <= '0;
		end else if (accept) begin
			cls        <= next_cls;
			cpu_src    <= (frm_port == PW'(CPU_PORT));
			key_src    <= frm_src_ip;
			key_dst    <= frm_dst_ip;
			key_l2_hit <= frm_l2_hit;
			key_l2_map <= frm_l2_map;
		end
	end

	// lookup sequencer: one entry address per cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state    <= ST_IDLE;
			scan_idx <= '0;
			rd_pend  <= 1'b0;
			rd_idx   <= '0;
		end else begin
			rd_pend <= (state == ST_SCAN) && (scan_idx < (EW+1)'(ENTRIES));
			rd_idx  <= scan_idx[EW-1:0];
			case (state)
				ST_IDLE: begin
					scan_idx <= '0;
					if (accept) begin
						state <= ST_SCAN;
					end
				end
				ST_SCAN: begin
					if (scan_idx < (EW+1)'(ENTRIES)) begin
						scan_idx <= scan_idx + (EW+1)'(1);
					end else if (!rd_pend) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign tbl.rd_addr = scan_idx[EW-1:0];
	assign {e_src, e_dst, e_mode, e_map} = tbl.rd_data;

	// match one entry against the frame addresses
	always_comb begin
		e_hit  = 1'b0;
		e_drop = 1'b0;
		if (rd_pend && ent_valid[rd_idx] && e_dst == key_dst) begin
			case (e_mode)
				MODE_INCLUDE: e_hit = (e_src == key_src);
				// exclude drops a listed source, forwards others
				MODE_EXCLUDE: begin
					e_hit  = 1'b1;
					e_drop = (e_src == key_src);
				end
				// also serves as wildcard-source include entry
				MODE_DONTCARE: e_hit = 1'b1;
				default: e_hit = 1'b0;
			endcase
		end
	end

	// first matching entry wins
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hit      <= 1'b0;
			hit_drop <= 1'b0;
			hit_map  <= '0;
		end else if (accept) begin
			hit      <= 1'b0;
			hit_drop <= 1'b0;
			hit_map  <= '0;
		end else if (e_hit && !hit) begin
			hit      <= 1'b1;
			hit_drop <= e_drop;
			hit_map  <= e_map;
		end
	end

	// learned ports join the router map when enabled
	assign router_map = (ctrl[CTRL_LEARN] ? learned : '0) | def_router;
	// fall back to L2 forwarding, then the default map
	assign fwd_map = hit ? hit_map : (key_l2_hit ? key_l2_map : def_mcast);

	// destination choice by frame class and snooping mode
	always_comb begin
		next_map  = '0;
		next_drop = 1'b0;
		if (cls != CLS_DATA && ctrl[CTRL_SW_SNOOP] && !cpu_src) begin
			// trap control frames to the CPU port
			next_map = CPU_MASK;
		end else if (cls != CLS_DATA && cpu_src) begin
			next_map = (cls == CLS_HOST) ? router_map : fwd_map;
		end else if (cls == CLS_HOST && ctrl[CTRL_HW_SNOOP]) begin
			// reports and leaves reach routers only
			next_map = router_map;
		end else if (cls == CLS_ROUTER && ctrl[CTRL_HW_SNOOP]) begin
			// known query uses table map plus routers
			// unknown query uses L2 map on L2 hit, else default map, plus routers
			next_map = fwd_map | router_map;
		end else if (hit && hit_drop) begin
			next_drop = 1'b1;
		end else begin
			// data frames get table map, else L2 or default map, plus routers
			next_map = fwd_map | router_map;
		end
	end

	// registered forwarding answer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			res_valid <= 1'b0;
			res_map   <= '0;
			res_drop  <= 1'b0;
			last_drop <= 1'b0;
		end else begin
			res_valid <= (state == ST_DONE);
			if (state == ST_DONE) begin
				res_map   <= next_map;
				res_drop  <= next_drop;
				last_drop <= next_drop;
			end
		end
	end
endmodule // mcast_snoop
`default_nettype wire

// >>> shared/mcast_snoop_pkg.sv
// package of constants for the multicast snooping forwarding block
// assumes a 32-bit register port and a 25 MHz core clock
package mcast_snoop_pkg;
	// clock rate and default router aging period
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned AGE_DEFAULT_MS = 1000;
	localparam int unsigned AGE_RESET      = CLK_HZ / 1000 * AGE_DEFAULT_MS;

	// register byte offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_DEF_ROUTER = 8'h04;
	localparam logic [7:0] REG_DEF_MCAST  = 8'h08;
	localparam logic [7:0] REG_AGE_PERIOD = 8'h0C;
	localparam logic [7:0] REG_LEARNED    = 8'h10;
	localparam logic [7:0] REG_STATUS     = 8'h14;
	localparam logic [7:0] REG_ENT_SRC    = 8'h20;
	localparam logic [7:0] REG_ENT_DST    = 8'h30;
	localparam logic [7:0] REG_ENT_CFG    = 8'h40;
	localparam logic [7:0] REG_ENT_CMD    = 8'h44;
	localparam logic [7:0] REG_ENT_VALID  = 8'h48;

	// control register fields
	localparam int CTRL_HW_SNOOP = 0;
	localparam int CTRL_SW_SNOOP = 1;
	localparam int CTRL_LEARN    = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// entry config and command fields
	localparam int CFG_MODE_LSB = 8;
	localparam int CMD_GO       = 8;

	// source filter modes of a table entry
	localparam logic [1:0] MODE_INCLUDE  = 2'h0;
	localparam logic [1:0] MODE_EXCLUDE  = 2'h1;
	localparam logic [1:0] MODE_DONTCARE = 2'h2;

	// control frame recognition codes
	localparam logic [7:0] PROTO_IGMP    = 8'h02;
	localparam logic [7:0] NEXT_HDR_MLD  = 8'h3A;
	localparam logic [7:0] IGMP_QUERY    = 8'h11;
	localparam logic [7:0] IGMP_V1_REP   = 8'h12;
	localparam logic [7:0] IGMP_V2_REP   = 8'h16;
	localparam logic [7:0] IGMP_LEAVE    = 8'h17;
	localparam logic [7:0] IGMP_HOST_A   = 8'h18;
	localparam logic [7:0] IGMP_HOST_B   = 8'h19;
	localparam logic [7:0] IGMP_HOST_C   = 8'h22;
	localparam logic [7:0] IGMP_RTR_A    = 8'h30;
	localparam logic [7:0] IGMP_RTR_B    = 8'h31;
	localparam logic [7:0] MLD_QUERY     = 8'h82;
	localparam logic [7:0] MLD_HOST_LO   = 8'h83;
	localparam logic [7:0] MLD_HOST_HI   = 8'h84;
	localparam logic [7:0] MLD_RTR_LO    = 8'h97;
	localparam logic [7:0] MLD_RTR_HI    = 8'h99;

	// lookup sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SCAN = 3'b010,
		ST_DONE = 3'b100
	} scan_state_e;
endpackage

// >>> shared/table_if.sv
// carrier between the lookup logic and its entry memory
// assumes the owner drives write and read address, the memory answers data
`timescale 1ns/1ns
`default_nettype none
interface table_if #(
	parameter int W  = 8,
	parameter int AW = 3
) ();
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [W-1:0]  wr_data;
	logic [AW-1:0] rd_addr;
	logic [W-1:0]  rd_data;

	modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem   (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// >>> core/entry_mem.sv
// small synchronous entry memory, registered read data
// assumes one clock; contents carry no reset, validity is kept by the owner
`timescale 1ns/1ns
`default_nettype none
module entry_mem #(
	parameter int DEPTH = 8
) (
	input  wire logic mclk,
	table_if.mem      tbl
);
	logic [$bits(tbl.rd_data)-1:0] store [DEPTH];

	// write port
	always_ff @(posedge mclk) begin
		if (tbl.wr_en) begin
			store[tbl.wr_addr] <= tbl.wr_data;
		end
	end

	// read port, data one cycle after address
	always_ff @(posedge mclk) begin
		tbl.rd_data <= store[tbl.rd_addr];
	end
endmodule // entry_mem
`default_nettype wire

// >>> core/router_aging.sv
// per-port learned router map with individual aging counters
// assumes learn is a one-cycle pulse from same-clock logic
`timescale 1ns/1ns
`default_nettype none
module router_aging #(
	parameter int NPORTS = 8,
	parameter int PW     = 3
) (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire logic              learn,
	input  wire logic [PW-1:0]     learn_port,
	input  wire logic [31:0]       period,
	output logic      [NPORTS-1:0] learned
);
	genvar g;
	generate
		for (g = 0; g < NPORTS; g++) begin : g_port
			logic [31:0] count;
			// restart on router message, drop the port on expiry
			always_ff @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					count      <= 32'h0;
					learned[g] <= 1'b0;
				end else if (learn && learn_port == PW'(g)) begin
					count      <= period;
					learned[g] <= 1'b1;
				end else if (learned[g]) begin
					if (count <= 32'h1) begin
						learned[g] <= 1'b0;
						count      <= 32'h0;
					end else begin
						count <= count - 32'h1;
					end
				end
			end
		end
	endgenerate
endmodule // router_aging
`default_nettype wire

// >>> bench/mcast_snoop_chk.sv
// port-level timing and trap checks for the multicast snooping block
// assumes it is bound to mcast_snoop and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module mcast_snoop_chk
	import mcast_snoop_pkg::*;
#(
	parameter int NPORTS   = 8,
	parameter int ENTRIES  = 8,
	parameter int CPU_PORT = 7,
	parameter int PW       = 3
) (
	input wire logic              mclk,
	input wire logic              reset_n,
	input wire logic [7:0]        reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	input wire logic              frm_valid,
	input wire logic              frm_ready,
	input wire logic [PW-1:0]     frm_port,
	input wire logic              frm_ipv4,
	input wire logic              frm_ipv6,
	input wire logic [7:0]        frm_proto,
	input wire logic [7:0]        frm_type,
	input wire logic              res_valid,
	input wire logic [NPORTS-1:0] res_map,
	input wire logic              res_drop
);
	localparam int LAT = ENTRIES + 4;
	logic acc;
	logic is_ctl;
	logic sw_on;
	// accept strobe and control frame class
	assign acc = frm_valid && frm_ready;
	assign is_ctl = (frm_ipv4 && frm_proto == PROTO_IGMP && frm_type inside {8'h11, 8'h12, 8'h16, 8'h17, 8'h18,
		8'h19, 8'h22, 8'h30, 8'h31}) || (frm_ipv6 && frm_proto == NEXT_HDR_MLD && frm_type inside {[8'h82:8'h84],
		[8'h97:8'h99]});
	// mirror of the software snooping enable
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) sw_on <= 1'b0;
		else if (reg_wr && reg_addr == REG_CTRL) sw_on <= reg_wdata[CTRL_SW_SNOOP];
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_accept;
		acc;
	endsequence
	sequence s_scan;
		!frm_ready [*8];
	endsequence
	a_ans_latency: assert property (s_accept |-> ##LAT res_valid)
		else $error("answer not at fixed latency");
	a_no_early: assert property (res_valid |-> $past(acc, LAT))
		else $error("answer without matching accept");
	a_busy_scan: assert property (s_accept |=> s_scan)
		else $error("ready during scan");
	a_ready_back: assert property (res_valid |-> frm_ready)
		else $error("not ready at answer");
	a_valid_pulse: assert property (res_valid |=> !res_valid)
		else $error("answer pulse too long");
	a_map_hold: assert property (!res_valid |-> $stable(res_map) && $stable(res_drop))
		else $error("answer changed between pulses");
	a_drop_empty: assert property (
		res_valid && res_drop |-> res_map == '0) else $error("dropped frame has destinations");
	a_sw_trap: assert property (
		s_accept ##0 (sw_on && is_ctl && frm_port != PW'(CPU_PORT)) |-> ##LAT res_map == NPORTS'(1 << CPU_PORT))
		else $error("control frame not trapped");
	a_rd_quiet: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without read");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule // mcast_snoop_chk
`default_nettype wire

// >>> bench/frame_src.sv
// frame descriptor source standing in for the ingress and CPU ports
// assumes one request pulse per frame, issued while the block is idle
`timescale 1ns/1ns
`default_nettype none
module frame_src #(
	parameter int DW = 286
) (
	input  wire logic          mclk,
	input  wire logic          reset_n,
	input  wire logic          go,
	input  wire logic [DW-1:0] desc,
	input  wire logic          frm_ready,
	output logic               frm_valid,
	output logic      [DW-1:0] frm_bus
);
	// hold descriptor until taken, then scramble the idle fields
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			frm_valid <= 1'b0;
			frm_bus   <= '0;
		end else if (go) begin
			frm_valid <= 1'b1;
			frm_bus   <= desc;
		end else if (frm_valid && frm_ready) begin
			frm_valid <= 1'b0;
			frm_bus   <= ~frm_bus;
		end
	end
endmodule // frame_src
`default_nettype wire

// >>> bench/tb_mcast_snoop.sv
// self-checking bench for the multicast snooping block
// assumes the package constants and a short router aging period
`timescale 1ns/1ns
`default_nettype none
module tb_mcast_snoop;
	import mcast_snoop_pkg::*;
	localparam int AGE = 20;
	localparam logic [31:0] SA = 32'h0A000001;
	localparam logic [31:0] SB = 32'h0A000002;
	localparam logic [7:0]  UDP = 8'h11;
	logic         mclk;
	logic         reset_n;
	logic [7:0]   reg_addr;
	logic [31:0]  reg_wdata;
	logic         reg_wr;
	logic         reg_rd;
	logic [31:0]  reg_rdata;
	logic         frm_valid;
	logic         frm_ready;
	logic         go;
	logic [285:0] desc;
	logic [285:0] frm_bus;
	logic [2:0]   frm_port;
	logic         frm_ipv4;
	logic         frm_ipv6;
	logic [7:0]   frm_proto;
	logic [7:0]   frm_type;
	logic [127:0] frm_src_ip;
	logic [127:0] frm_dst_ip;
	logic         frm_l2_hit;
	logic [7:0]   frm_l2_map;
	logic         res_valid;
	logic [7:0]   res_map;
	logic         res_drop;
	int           n_errors;
	int           compares;
	int           i;
	logic [7:0]   tys [13] = '{8'h12, 8'h18, 8'h19, 8'h22, 8'h11, 8'h30, 8'h31, 8'h83, 8'h84, 8'h82, 8'h97, 8'h98, 8'h99};
	// descriptor fields from the partner
	assign {frm_port, frm_ipv4, frm_ipv6, frm_proto, frm_type, frm_src_ip, frm_dst_ip, frm_l2_hit, frm_l2_map} = frm_bus;
	mcast_snoop #(.AGE_INIT(AGE)) i_mcast_snoop (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_valid(frm_valid),
		.frm_ready(frm_ready), .frm_port(frm_port), .frm_ipv4(frm_ipv4), .frm_ipv6(frm_ipv6), .frm_proto(frm_proto),
		.frm_type(frm_type), .frm_src_ip(frm_src_ip), .frm_dst_ip(frm_dst_ip), .frm_l2_hit(frm_l2_hit),
		.frm_l2_map(frm_l2_map), .res_valid(res_valid), .res_map(res_map), .res_drop(res_drop));
	frame_src i_frame_src (.mclk(mclk), .reset_n(reset_n), .go(go), .desc(desc), .frm_ready(frm_ready),
		.frm_valid(frm_valid), .frm_bus(frm_bus));
	// 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic final_report();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data is taken in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		chk(reg_rdata, exp);
	endtask
	// one frame; l2 is {hit, map}, exp is {drop, map}
	task automatic send(input logic [2:0] p, input logic v4, input logic [7:0] pr, input logic [7:0] ty,
		input logic [31:0] s, input logic [31:0] d, input logic [8:0] l2, input logic [8:0] exp);
		int k;
		@(posedge mclk);
		desc <= {p, v4, !v4, pr, ty, 96'h0, s, 96'h0, d, l2};
		go   <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		for (k = 0; k < 40 && res_valid !== 1'b1; k++) @(posedge mclk);
		if (k == 40) begin
			n_errors++;
			final_report();
		end else begin
			chk({23'h0, res_drop, res_map}, {23'h0, exp});
		end
	endtask
	// stage addresses and config, then commit to one entry
	task automatic ent(input logic [2:0] idx, input logic [31:0] s, input logic [31:0] d, input logic [9:0] cfg);
		int k;
		wr(REG_ENT_SRC, s);
		wr(REG_ENT_DST, d);
		for (k = 1; k < 4; k++) begin
			wr(REG_ENT_SRC + 8'(4 * k), 32'h0);
			wr(REG_ENT_DST + 8'(4 * k), 32'h0);
		end
		wr(REG_ENT_CFG, {22'h0, cfg});
		wr(REG_ENT_CMD, {23'h0, 1'b1, 5'h0, idx});
	endtask
	// main sequence
	initial begin
		{reset_n, reg_addr, reg_wdata, reg_wr, reg_rd, go, desc, n_errors, compares} = '0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		rchk(REG_CTRL, 32'h0);
		rchk(REG_LEARNED, 32'h0);
		rchk(REG_AGE_PERIOD, 32'(AGE));
		rchk(REG_ENT_VALID, 32'h0);
		rchk(8'hFC, 32'h0);
		$display("test reset done");
		wr(REG_DEF_ROUTER, 32'h01);
		wr(REG_DEF_MCAST, 32'h40);
		wr(REG_AGE_PERIOD, 32'h1E);
		wr(REG_CTRL, 32'h5);
		send(3'd2, 1'b1, PROTO_IGMP, IGMP_QUERY, SA, 32'h0, 9'h0, 9'h045);
		rchk(REG_LEARNED, 32'h04);
		send(3'd3, 1'b1, PROTO_IGMP, IGMP_V2_REP, SB, 32'hE0000101, 9'h0, 9'h005);
		repeat (20) @(posedge mclk);
		send(3'd4, 1'b1, PROTO_IGMP, IGMP_QUERY, SA, 32'h0, 9'h0, 9'h051);
		rchk(REG_LEARNED, 32'h10);
		// a second router message restarts the timer past its first expiry
		send(3'd4, 1'b1, PROTO_IGMP, IGMP_QUERY, SA, 32'h0, 9'h0, 9'h051);
		rchk(REG_LEARNED, 32'h10);
		repeat (40) @(posedge mclk);
		rchk(REG_LEARNED, 32'h0);
		send(3'd3, 1'b1, PROTO_IGMP, IGMP_LEAVE, SB, 32'hE0000101, 9'h0, 9'h001);
		$display("test router done");
		wr(REG_CTRL, 32'h2);
		for (i = 0; i < 13; i++) begin
			send(3'd1, i < 7, i < 7 ? PROTO_IGMP : NEXT_HDR_MLD, tys[i], SB, 32'h0, 9'h0, 9'h080);
		end
		send(3'd1, 1'b1, PROTO_IGMP, 8'h20, SB, 32'h0, 9'h0, 9'h041);
		send(3'd7, 1'b1, PROTO_IGMP, IGMP_V2_REP, SB, 32'h0, 9'h0, 9'h001);
		send(3'd7, 1'b1, PROTO_IGMP, IGMP_RTR_A, SB, 32'h0, 9'h0, 9'h040);
		send(3'd7, 1'b0, NEXT_HDR_MLD, MLD_QUERY, SB, 32'h0, 9'h122, 9'h022);
		$display("test trap done");
		ent(3'd0, SA, 32'hE0000101, {MODE_INCLUDE, 8'h0C});
		ent(3'd1, SA, 32'hE0000102, {MODE_EXCLUDE, 8'h30});
		ent(3'd2, 32'h0, 32'hE0000103, {MODE_DONTCARE, 8'h02});
		ent(3'd3, SA, 32'hE0000104, {MODE_INCLUDE, 8'h08});
		ent(3'd4, 32'h0, 32'hE0000104, {MODE_DONTCARE, 8'h0C});
		rchk(REG_ENT_VALID, 32'h1F);
		send(3'd0, 1'b1, UDP, 8'h00, SA, 32'hE0000101, 9'h0, 9'h00D);
		send(3'd0, 1'b1, UDP, 8'h00, SB, 32'hE0000101, 9'h120, 9'h021);
		send(3'd0, 1'b1, UDP, 8'h00, SA, 32'hE0000102, 9'h0, 9'h100);
		send(3'd0, 1'b1, UDP, 8'h00, SB, 32'hE0000102, 9'h0, 9'h031);
		send(3'd0, 1'b1, UDP, 8'h00, SB, 32'hE0000103, 9'h0, 9'h003);
		send(3'd0, 1'b1, UDP, 8'h00, SA, 32'hE0000104, 9'h0, 9'h009);
		send(3'd0, 1'b1, UDP, 8'h00, SB, 32'hE0000104, 9'h0, 9'h00D);
		ent(3'd0, SA, 32'hE0000101, {MODE_INCLUDE, 8'h00});
		rchk(REG_ENT_VALID, 32'h1E);
		send(3'd0, 1'b1, UDP, 8'h00, SA, 32'hE0000101, 9'h0, 9'h041);
		$display("test table done");
		wr(REG_CTRL, 32'h1);
		send(3'd5, 1'b1, PROTO_IGMP, IGMP_QUERY, SA, 32'hE0000103, 9'h0, 9'h003);
		send(3'd5, 1'b1, PROTO_IGMP, IGMP_QUERY, SA, 32'hE0000109, 9'h124, 9'h025);
		$display("test query done");
		final_report();
	end
endmodule // tb_mcast_snoop
bind mcast_snoop mcast_snoop_chk #(.NPORTS(NPORTS), .ENTRIES(ENTRIES), .CPU_PORT(CPU_PORT), .PW(PW)) u_chk (
	.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_valid(frm_valid), .frm_ready(frm_ready), .frm_port(frm_port),
	.frm_ipv4(frm_ipv4), .frm_ipv6(frm_ipv6), .frm_proto(frm_proto), .frm_type(frm_type),
	.res_valid(res_valid), .res_map(res_map), .res_drop(res_drop));
`default_nettype wire
